// [core/ssu_pkg.sv]
package ssu_pkg;
    // register byte offsets
    localparam logic [7:0] SSU_OFF_CMD = 8'h00;
    localparam logic [7:0] SSU_OFF_DST = 8'h04;
    localparam logic [7:0] SSU_OFF_SRC = 8'h08;
    localparam logic [7:0] SSU_OFF_PAIR = 8'h0c;
    localparam logic [7:0] SSU_OFF_PSW = 8'h10;
    localparam logic [7:0] SSU_OFF_RES_HI = 8'h14;
    localparam logic [7:0] SSU_OFF_RES_LO = 8'h18;
    localparam logic [7:0] SSU_OFF_STATUS = 8'h1c;
    // status field positions
    localparam int SSU_ST_BUSY = 0;
    localparam int SSU_ST_DONE = 1;
    localparam int SSU_ST_BAD = 2;
    localparam int SSU_ST_FLAGS = 4;
    // flag positions within nzvc nibble
    localparam int SSU_F_N = 3;
    localparam int SSU_F_Z = 2;
    localparam int SSU_F_V = 1;
    localparam int SSU_F_C = 0;
    // opcode fields (instruction word, octal groups in hex form)
    localparam logic [8:0] SSU_OP_SHR1 = 9'h032;
    localparam logic [8:0] SSU_OP_SHL1 = 9'h033;
    localparam logic [6:0] SSU_OP_MULTI = 7'h3a;
    localparam logic [6:0] SSU_OP_PAIR = 7'h3b;
    localparam logic [9:0] SSU_OP_FILL = 10'h037;
    localparam logic [9:0] SSU_OP_XCHG = 10'h003;
    // reset values
    localparam logic [15:0] SSU_RST_WORD = 16'h0000;
    localparam logic [3:0] SSU_RST_FLAGS = 4'h0;
    // axi responses
    localparam logic [1:0] SSU_RESP_OKAY = 2'b00;
    localparam logic [1:0] SSU_RESP_SLVERR = 2'b10;
    // operand width modes
    typedef enum logic [1:0] {
        SSU_W_BYTE = 2'b00,
        SSU_W_WORD = 2'b01,
        SSU_W_LONG = 2'b10
    } ssu_width_t;
    // gray along idle -> shift -> finish
    typedef enum logic [1:0] {
        SSU_IDLE = 2'b00,
        SSU_SHIFT = 2'b01,
        SSU_FINISH = 2'b11
    } ssu_state_t;
endpackage

// [core/ssu_core.sv]
// Summary of operation
// - One-place right shift moves every bit right one place and keeps the top bit in place.
// - After one-place right shift carry is the old low bit, N and Z follow the result, V is N xor C.
// - One-place left shift moves every bit left, fills a zero at the bottom, carry takes the old top bit.
// - After one-place left shift N and Z follow the result and V is the xor of final N and C.
// - Multi-place shift of one register takes its count from the low six bits of the source.
// - Both multi-place shifts read the count as signed -32..+31, negative right, positive left.
// - Multi-place register shift sets V if the sign ever changed, C is the last bit out, N Z from result.
// - Pair shift joins the selected register (high half) and the register or-ed with one (low half).
// - Pair shift on an odd register uses one word for both halves so a right shift rotates it.
// - After pair shift V flags any sign change, C is the last bit out, N Z follow the 32-bit result.
// - Sign fill writes all ones when N is set and zero when N is clear.
// - Sign fill keeps N and C, clears V and sets Z exactly when N was clear.
// - Byte exchange swaps the upper and lower bytes of a word.
// - After byte exchange N is result bit 7, Z flags a zero low byte, V and C are cleared.
//
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
module ssu_core (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // axi4-lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // bus side state
    logic [7:0] awaddr_q, awaddr_d;
    logic aw_full_q, aw_full_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic w_full_q, w_full_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic rvalid_q, rvalid_d;
    logic [1:0] rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic [15:0] cmd_q, cmd_d;
    logic [15:0] dst_q, dst_d;
    logic [15:0] src_q, src_d;
    logic [15:0] pair_q, pair_d;
    logic [3:0] psw_q, psw_d;
    logic start;
    // engine state
    ssu_pkg::ssu_state_t state_q, state_d;
    ssu_pkg::ssu_width_t width_q, width_d;
    logic [31:0] acc_q, acc_d;
    logic [5:0] steps_q, steps_d;
    logic left_q, left_d;
    logic multi_q, multi_d;
    logic odd_q, odd_d;
    logic c_q, c_d;
    logic v_q, v_d;
    logic [15:0] res_hi_q, res_hi_d;
    logic [15:0] res_lo_q, res_lo_d;
    logic [3:0] flags_q, flags_d;
    logic done_q, done_d;
    logic bad_q, bad_d;

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
        logic [15:0] r;
        r = old;
        if (be[0]) begin
            r[7:0] = wd[7:0];
        end
        if (be[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction

    assign s_axi_awready = !aw_full_q;
    assign s_axi_wready = !w_full_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;

    // bus slave: address and data taken in either order, response after both
    always_comb begin
        awaddr_d = awaddr_q;
        aw_full_d = aw_full_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        w_full_d = w_full_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        cmd_d = cmd_q;
        dst_d = dst_q;
        src_d = src_q;
        pair_d = pair_q;
        psw_d = psw_q;
        start = 1'b0;
        if (s_axi_awvalid && !aw_full_q) begin
            awaddr_d = s_axi_awaddr;
            aw_full_d = 1'b1;
        end
        if (s_axi_wvalid && !w_full_q) begin
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
            w_full_d = 1'b1;
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (aw_full_q && w_full_q && !bvalid_q) begin
            aw_full_d = 1'b0;
            w_full_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = ssu_pkg::SSU_RESP_OKAY;
            if (awaddr_q == ssu_pkg::SSU_OFF_CMD) begin
                // a command written while busy is dropped, operands stay coherent
                if (state_q == ssu_pkg::SSU_IDLE) begin
                    cmd_d = merge16(cmd_q, wdata_q, wstrb_q);
                    start = 1'b1;
                end
            end else if (awaddr_q == ssu_pkg::SSU_OFF_DST) begin
                dst_d = merge16(dst_q, wdata_q, wstrb_q);
            end else if (awaddr_q == ssu_pkg::SSU_OFF_SRC) begin
                src_d = merge16(src_q, wdata_q, wstrb_q);
            end else if (awaddr_q == ssu_pkg::SSU_OFF_PAIR) begin
                pair_d = merge16(pair_q, wdata_q, wstrb_q);
            end else if (awaddr_q == ssu_pkg::SSU_OFF_PSW) begin
                if (wstrb_q[0]) begin
                    psw_d = wdata_q[3:0];
                end
            end else if (awaddr_q == ssu_pkg::SSU_OFF_RES_HI || awaddr_q == ssu_pkg::SSU_OFF_RES_LO
                         || awaddr_q == ssu_pkg::SSU_OFF_STATUS) begin
                bresp_d = ssu_pkg::SSU_RESP_OKAY;
            end else begin
                bresp_d = ssu_pkg::SSU_RESP_SLVERR;
            end
        end
        if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        if (s_axi_arvalid && !rvalid_q) begin
            rvalid_d = 1'b1;
            rresp_d = ssu_pkg::SSU_RESP_OKAY;
            rdata_d = 32'h0000_0000;
            if (s_axi_araddr == ssu_pkg::SSU_OFF_CMD) begin
                rdata_d[15:0] = cmd_q;
            end else if (s_axi_araddr == ssu_pkg::SSU_OFF_DST) begin
                rdata_d[15:0] = dst_q;
            end else if (s_axi_araddr == ssu_pkg::SSU_OFF_SRC) begin
                rdata_d[15:0] = src_q;
            end else if (s_axi_araddr == ssu_pkg::SSU_OFF_PAIR) begin
                rdata_d[15:0] = pair_q;
            end else if (s_axi_araddr == ssu_pkg::SSU_OFF_PSW) begin
                rdata_d[3:0] = psw_q;
            end else if (s_axi_araddr == ssu_pkg::SSU_OFF_RES_HI) begin
                rdata_d[15:0] = res_hi_q;
            end else if (s_axi_araddr == ssu_pkg::SSU_OFF_RES_LO) begin
                rdata_d[15:0] = res_lo_q;
            end else if (s_axi_araddr == ssu_pkg::SSU_OFF_STATUS) begin
                rdata_d[ssu_pkg::SSU_ST_BUSY] = (state_q != ssu_pkg::SSU_IDLE);
                rdata_d[ssu_pkg::SSU_ST_DONE] = done_q;
                rdata_d[ssu_pkg::SSU_ST_BAD] = bad_q;
                rdata_d[ssu_pkg::SSU_ST_FLAGS +: 4] = flags_q;
            end else begin
                rresp_d = ssu_pkg::SSU_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            awaddr_q <= 8'h00;
            aw_full_q <= 1'b0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            w_full_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= ssu_pkg::SSU_RESP_OKAY;
            rvalid_q <= 1'b0;
            rresp_q <= ssu_pkg::SSU_RESP_OKAY;
            rdata_q <= 32'h0000_0000;
            cmd_q <= ssu_pkg::SSU_RST_WORD;
            dst_q <= ssu_pkg::SSU_RST_WORD;
            src_q <= ssu_pkg::SSU_RST_WORD;
            pair_q <= ssu_pkg::SSU_RST_WORD;
            psw_q <= ssu_pkg::SSU_RST_FLAGS;
        end else begin
            awaddr_q <= awaddr_d;
            aw_full_q <= aw_full_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            w_full_q <= w_full_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
            cmd_q <= cmd_d;
            dst_q <= dst_d;
            src_q <= src_d;
            pair_q <= pair_d;
            psw_q <= psw_d;
        end
    end

    // engine: operand left-justified in acc so bit 31 is always the sign
    logic [5:0] count6;
    logic [5:0] mag;
    logic fin_n, fin_z;
    always_comb begin
        state_d = state_q;
        width_d = width_q;
        acc_d = acc_q;
        steps_d = steps_q;
        left_d = left_q;
        multi_d = multi_q;
        odd_d = odd_q;
        c_d = c_q;
        v_d = v_q;
        res_hi_d = res_hi_q;
        res_lo_d = res_lo_q;
        flags_d = flags_q;
        done_d = done_q;
        bad_d = bad_q;
        count6 = src_q[5:0];
        mag = count6[5] ? 6'(-count6) : count6;
        fin_n = acc_q[31];
        fin_z = 1'b0;
        case (state_q)
            ssu_pkg::SSU_IDLE: begin
                if (start) begin
                    done_d = 1'b0;
                    bad_d = 1'b0;
                    c_d = 1'b0;
                    v_d = 1'b0;
                    odd_d = 1'b0;
                    multi_d = 1'b0;
                    steps_d = 6'h01;
                    if (cmd_d[14:6] == ssu_pkg::SSU_OP_SHR1
                        || cmd_d[14:6] == ssu_pkg::SSU_OP_SHL1) begin
                        left_d = (cmd_d[14:6] == ssu_pkg::SSU_OP_SHL1);
                        if (cmd_d[15]) begin
                            width_d = ssu_pkg::SSU_W_BYTE;
                            acc_d = {dst_q[7:0], 24'h00_0000};
                        end else begin
                            width_d = ssu_pkg::SSU_W_WORD;
                            acc_d = {dst_q, 16'h0000};
                        end
                        state_d = ssu_pkg::SSU_SHIFT;
                    end else if (cmd_d[15:9] == ssu_pkg::SSU_OP_MULTI) begin
                        multi_d = 1'b1;
                        width_d = ssu_pkg::SSU_W_WORD;
                        acc_d = {dst_q, 16'h0000};
                        left_d = !count6[5];
                        steps_d = mag;
                        state_d = ssu_pkg::SSU_SHIFT;
                    end else if (cmd_d[15:9] == ssu_pkg::SSU_OP_PAIR) begin
                        multi_d = 1'b1;
                        width_d = ssu_pkg::SSU_W_LONG;
                        odd_d = cmd_d[6];
                        // odd register feeds both halves, so right shifts wrap round
                        acc_d = {dst_q, cmd_d[6] ? dst_q : pair_q};
                        left_d = !count6[5];
                        steps_d = mag;
                        state_d = ssu_pkg::SSU_SHIFT;
                    end else if (cmd_d[15:6] == ssu_pkg::SSU_OP_FILL) begin
                        res_hi_d = psw_q[ssu_pkg::SSU_F_N] ? 16'hffff : 16'h0000;
                        flags_d = psw_q;
                        flags_d[ssu_pkg::SSU_F_V] = 1'b0;
                        flags_d[ssu_pkg::SSU_F_Z] = !psw_q[ssu_pkg::SSU_F_N];
                        done_d = 1'b1;
                    end else if (cmd_d[15:6] == ssu_pkg::SSU_OP_XCHG) begin
                        res_hi_d = {dst_q[7:0], dst_q[15:8]};
                        flags_d = {dst_q[15], (dst_q[15:8] == 8'h00), 2'b00};
                        done_d = 1'b1;
                    end else begin
                        // unknown instruction: results left untouched
                        bad_d = 1'b1;
                        done_d = 1'b1;
                    end
                end
            end
            ssu_pkg::SSU_SHIFT: begin
                if (steps_q == 6'h00) begin
                    state_d = ssu_pkg::SSU_FINISH;
                end else begin
                    steps_d = steps_q - 6'h01;
                    if (left_q) begin
                        c_d = acc_q[31];
                        acc_d = {acc_q[30:0], 1'b0};
                        if (acc_q[30] != acc_q[31]) begin
                            v_d = 1'b1;
                        end
                    end else begin
                        if (width_q == ssu_pkg::SSU_W_BYTE) begin
                            c_d = acc_q[24];
                        end else if (width_q == ssu_pkg::SSU_W_WORD) begin
                            c_d = acc_q[16];
                        end else begin
                            c_d = acc_q[0];
                        end
                        acc_d = {acc_q[31], acc_q[31:1]};
                    end
                    if (steps_q == 6'h01) begin
                        state_d = ssu_pkg::SSU_FINISH;
                    end
                end
            end
            ssu_pkg::SSU_FINISH: begin
                if (width_q == ssu_pkg::SSU_W_BYTE) begin
                    fin_z = (acc_q[31:24] == 8'h00);
                    res_hi_d = {dst_q[15:8], acc_q[31:24]};
                end else if (width_q == ssu_pkg::SSU_W_WORD) begin
                    fin_z = (acc_q[31:16] == 16'h0000);
                    res_hi_d = acc_q[31:16];
                    res_lo_d = pair_q;
                end else begin
                    fin_z = (acc_q == 32'h0000_0000);
                    // odd pair: the last write of the shared register wins
                    res_hi_d = odd_q ? acc_q[15:0] : acc_q[31:16];
                    res_lo_d = acc_q[15:0];
                end
                flags_d[ssu_pkg::SSU_F_N] = fin_n;
                flags_d[ssu_pkg::SSU_F_Z] = fin_z;
                flags_d[ssu_pkg::SSU_F_C] = c_q;
                flags_d[ssu_pkg::SSU_F_V] = multi_q ? v_q : (fin_n ^ c_q);
                done_d = 1'b1;
                state_d = ssu_pkg::SSU_IDLE;
            end
            default: begin
                state_d = ssu_pkg::SSU_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q <= ssu_pkg::SSU_IDLE;
            width_q <= ssu_pkg::SSU_W_WORD;
            acc_q <= 32'h0000_0000;
            steps_q <= 6'h00;
            left_q <= 1'b0;
            multi_q <= 1'b0;
            odd_q <= 1'b0;
            c_q <= 1'b0;
            v_q <= 1'b0;
            res_hi_q <= ssu_pkg::SSU_RST_WORD;
            res_lo_q <= ssu_pkg::SSU_RST_WORD;
            flags_q <= ssu_pkg::SSU_RST_FLAGS;
            done_q <= 1'b0;
            bad_q <= 1'b0;
        end else begin
            state_q <= state_d;
            width_q <= width_d;
            acc_q <= acc_d;
            steps_q <= steps_d;
            left_q <= left_d;
            multi_q <= multi_d;
            odd_q <= odd_d;
            c_q <= c_d;
            v_q <= v_d;
            res_hi_q <= res_hi_d;
            res_lo_q <= res_lo_d;
            flags_q <= flags_d;
            done_q <= done_d;
            bad_q <= bad_d;
        end
    end
endmodule // ssu_core

// [dv/ssu_checker.sv]
module ssu_checker (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // write channels
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read channels
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response lost early");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read data lost early");
    read_answer_a: assert property (rd_taken |=> s_axi_rvalid) else $error("no read answer");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar taken early");
    write_answer_a: assert property (wr_taken |-> ##[1:3] s_axi_bvalid)
        else $error("no write answer");
    aw_refuse_a: assert property (wr_taken |=> !s_axi_awready && !s_axi_wready)
        else $error("second write accepted");
    ready_back_a: assert property ($rose(s_axi_bvalid) |-> s_axi_awready && s_axi_wready)
        else $error("write channels stay blocked");
    bvalid_clear_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    rd_slverr_a: assert property (rd_taken ##0 (s_axi_araddr >= 8'h20) |=>
        s_axi_rresp == ssu_pkg::SSU_RESP_SLVERR && s_axi_rdata == 32'h00000000)
        else $error("unmapped read not refused");
    wr_slverr_a: assert property (wr_taken ##0 (s_axi_awaddr >= 8'h20) |=>
        ##[0:2] (s_axi_bvalid && s_axi_bresp == ssu_pkg::SSU_RESP_SLVERR))
        else $error("unmapped write not refused");
endmodule // ssu_checker

bind ssu_core ssu_checker i_chk (
    .sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);

// [dv/tb_shift_sign_swap_unit.sv]
module tb_shift_sign_swap_unit;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h00000000;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, res_hi, res_lo, res_f;
    int bad_count = 0;
    int cmp_count = 0;

    ssu_core i_dut (
        .sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
    );

    always #5 sys_clk = ~sys_clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        if (bad_count == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // handshakes judged at the falling edge, so no race with the design's edge
    task automatic wr(input logic [7:0] a, input logic [15:0] d,
        input logic [1:0] er = ssu_pkg::SSU_RESP_OKAY);
        logic aw_t, w_t, b_t;
        int n;
        n = 0;
        b_t = 1'b0;
        // idle edge first, so bready is never driven twice in one step
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= {16'h0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!b_t && n < 50) begin
            @(negedge sys_clk);
            aw_t = awvalid && awready;
            w_t = wvalid && wready;
            b_t = bvalid && bready;
            if (b_t) chk({30'h0, bresp}, {30'h0, er});
            @(posedge sys_clk);
            if (aw_t) awvalid <= 1'b0;
            if (w_t) wvalid <= 1'b0;
            n++;
        end
        bready <= 1'b0;
        if (!b_t) chk(32'h0, 32'h1);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d,
        input logic [1:0] er = ssu_pkg::SSU_RESP_OKAY);
        logic ar_t, r_t;
        int n;
        n = 0;
        r_t = 1'b0;
        // idle edge first, so rready is never driven twice in one step
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!r_t && n < 50) begin
            @(negedge sys_clk);
            ar_t = arvalid && arready;
            r_t = rvalid && rready;
            d = rdata;
            if (r_t) chk({30'h0, rresp}, {30'h0, er});
            @(posedge sys_clk);
            if (ar_t) arvalid <= 1'b0;
            n++;
        end
        rready <= 1'b0;
        if (!r_t) chk(32'h0, 32'h1);
    endtask

    // load operands, start, poll for done, fetch results and nzvc
    task automatic run(input logic [15:0] cmd, dst, src, pair, psw);
        logic [31:0] st;
        int n;
        st = 32'h0;
        n = 0;
        wr(ssu_pkg::SSU_OFF_DST, dst);
        wr(ssu_pkg::SSU_OFF_SRC, src);
        wr(ssu_pkg::SSU_OFF_PAIR, pair);
        wr(ssu_pkg::SSU_OFF_PSW, psw);
        wr(ssu_pkg::SSU_OFF_CMD, cmd);
        while (st[1:0] !== 2'b10 && n < 80) begin
            rd(ssu_pkg::SSU_OFF_STATUS, st);
            n++;
        end
        chk({30'h0, st[1:0]}, 32'h2);
        rd(ssu_pkg::SSU_OFF_RES_HI, res_hi);
        rd(ssu_pkg::SSU_OFF_RES_LO, res_lo);
        res_f = {28'h0000000, st[7:4]};
    endtask

    task automatic t_shr();
        run(16'h0c80, 16'h8001, 16'h0, 16'h0, 16'h0);
        chk(res_hi, 32'hc000);
        chk(res_f, 32'h9);
        run(16'h0c80, 16'h0001, 16'h0, 16'h0, 16'h0);
        chk(res_hi, 32'h0);
        chk(res_f, 32'h7);
    endtask

    task automatic t_shl();
        run(16'h0cc0, 16'h4000, 16'h0, 16'h0, 16'h0);
        chk(res_hi, 32'h8000);
        chk(res_f, 32'ha);
        run(16'h0cc0, 16'h8000, 16'h0, 16'h0, 16'h0);
        chk(res_hi, 32'h0);
        chk(res_f, 32'h7);
    endtask

    // high byte must pass through untouched
    task automatic t_byte();
        run(16'h8c80, 16'h1281, 16'h0, 16'h0, 16'h0);
        chk(res_hi, 32'h12c0);
        chk(res_f, 32'h9);
        run(16'h8cc0, 16'hff80, 16'h0, 16'h0, 16'h0);
        chk(res_hi, 32'hff00);
        chk(res_f, 32'h7);
    endtask

    task automatic t_multi();
        run(16'h7400, 16'h4001, 16'h0002, 16'h0, 16'h0);
        chk(res_hi, 32'h0004);
        chk(res_f, 32'h3);
        run(16'h7400, 16'h8005, 16'h003e, 16'h0, 16'h0);
        chk(res_hi, 32'he001);
        chk(res_f, 32'h8);
        run(16'h7400, 16'h8000, 16'hffe0, 16'h0, 16'h0);
        chk(res_hi, 32'hffff);
        chk(res_f, 32'h9);
        run(16'h7400, 16'h0001, 16'h001f, 16'h0, 16'h0);
        chk(res_f, 32'h6);
        run(16'h7400, 16'h0000, 16'h0040, 16'h0, 16'h000f);
        chk(res_f, 32'h4);
    endtask

    task automatic t_pair();
        run(16'h7600, 16'h4000, 16'h0002, 16'h8000, 16'h0);
        chk(res_hi, 32'h0002);
        chk(res_f, 32'h3);
        run(16'h7600, 16'h0001, 16'h003f, 16'h0000, 16'h0);
        chk(res_lo, 32'h8000);
        chk(res_f, 32'h0);
        run(16'h7640, 16'h1234, 16'h003c, 16'hffff, 16'h0);
        chk(res_hi, 32'h4123);
        chk(res_lo, 32'h4123);
    endtask

    task automatic t_fill_xchg();
        run(16'h0dc0, 16'h1234, 16'h0, 16'h0, 16'h000b);
        chk(res_hi, 32'hffff);
        chk(res_f, 32'h9);
        run(16'h0dc0, 16'h1234, 16'h0, 16'h0, 16'h0003);
        chk(res_hi, 32'h0);
        chk(res_f, 32'h5);
        run(16'h00c0, 16'h80ff, 16'h0, 16'h0, 16'h0003);
        chk(res_hi, 32'hff80);
        chk(res_f, 32'h8);
        run(16'h00c0, 16'h00aa, 16'h0, 16'h0, 16'h0003);
        chk(res_hi, 32'haa00);
        chk(res_f, 32'h4);
    endtask

    // read-only and unmapped places, after the last exchange
    task automatic t_bus();
        logic [31:0] d;
        wr(ssu_pkg::SSU_OFF_RES_HI, 16'h5555);
        rd(ssu_pkg::SSU_OFF_RES_HI, d);
        chk(d, 32'haa00);
        rd(ssu_pkg::SSU_OFF_CMD, d);
        chk(d, 32'h00c0);
        rd(8'h20, d, ssu_pkg::SSU_RESP_SLVERR);
        chk(d, 32'h0);
        wr(8'h24, 16'h1111, ssu_pkg::SSU_RESP_SLVERR);
        // unknown opcode: flagged, results and flags left alone
        run(16'h0000, 16'h0, 16'h0, 16'h0, 16'h0);
        chk(res_hi, 32'haa00);
        chk(res_f, 32'h4);
        rd(ssu_pkg::SSU_OFF_STATUS, d);
        chk(d, 32'h46);
    endtask

    initial begin
        logic [31:0] d;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        rd(ssu_pkg::SSU_OFF_DST, d);
        chk(d, 32'h0);
        rd(ssu_pkg::SSU_OFF_STATUS, d);
        chk(d, 32'h0);
        t_shr();
        t_shl();
        t_byte();
        t_multi();
        t_pair();
        t_fill_xchg();
        t_bus();
        print_verdict();
    end

    // the whole run needs well under a thousand cycles
    initial begin
        #200000;
        bad_count++;
        print_verdict();
    end
endmodule // tb_shift_sign_swap_unit
